/* File: brake_limit_defines.svh */
// Register offsets, field positions, reset values and timing counts for the brake/limit control
`ifndef BRAKE_LIMIT_DEFINES_SVH
`define BRAKE_LIMIT_DEFINES_SVH

// Register byte offsets
`define OFS_NEUTRAL_CTRL   12'h000
`define OFS_LIMIT_CTRL     12'h004
`define OFS_SENSE_CTRL     12'h008
`define OFS_STATUS         12'h00C

// Neutral control fields
`define NEU_SEL_LSB        0
`define NEU_SEL_W          2
`define NEU_STORED_BIT     4
`define NEU_BUTTON_BIT     5

// Limit control fields
`define LIM_CFG_LSB        0
`define LIM_CFG_W          2
`define LIM_OVR_BIT        4
`define LIM_FWD_EN_BIT     5
`define LIM_REV_EN_BIT     6

// Sense control fields: 1 means normally open
`define SNS_FWD_NO_BIT     0
`define SNS_REV_NO_BIT     1

// Status fields
`define ST_BRAKE_BIT       0
`define ST_FWD_ON_BIT      1
`define ST_FWD_OFF_BIT     2
`define ST_REV_ON_BIT      3
`define ST_REV_OFF_BIT     4
`define ST_FWD_BLK_BIT     5
`define ST_REV_BLK_BIT     6
`define ST_DRV_EN_BIT      7
`define ST_FWD_SW_BIT      8
`define ST_REV_SW_BIT      9

// Reset values
`define RST_STORED_BRAKE   1'b1
`define RST_SENSE_NO       1'b1

// Drive pause on sense change
`define PAUSE_TIME_US      10
`define CLK_MHZ            250
`define PAUSE_CYCLES       (`PAUSE_TIME_US * `CLK_MHZ)

`endif

/* File: brake_limit_override_ctrl.sv */
// APB-controlled neutral mode, limit enable override and limit sense logic
// Notes on behaviour
// - Neutral override replaces stored startup mode
// - LED lit for brake, dark for coast
// - Forward and reverse enables forced independently
// - Status reports forced on/off per direction
// - Status reports active neutral mode
// - No override falls back to stored mode
// - Three limit configurations supported
// - Default-select cancels any neutral override
// - Each input sense set separately
// - Sense change pauses drive then resumes
// - Inputs reset to normally-open sense
// - Button toggles stored startup neutral mode
//
// Local design decisions: the APB slave port and the placing of the registers.
`include "brake_limit_defines.svh"

module brake_limit_override_ctrl #(
    parameter int PAUSE_CYCLES = `PAUSE_CYCLES  // Drive pause length, shortenable
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cal_button,     // One-cycle press of brake/coast button
    input  wire logic        fwd_switch_closed,
    input  wire logic        rev_switch_closed,
    output logic             brake_led,      // High lights the LED red
    output logic             brake_active,   // Neutral behaviour: 1 brake, 0 coast
    output logic             drive_enable,
    output logic             fwd_blocked,
    output logic             rev_blocked
);

    // Pause counter is 24 bits; zero or longer pauses cannot be served
    if (PAUSE_CYCLES < 1 || PAUSE_CYCLES > 32'hFF_FFFF)
    begin : g_bad_pause
        $error("PAUSE_CYCLES out of range");
    end

    // Software-visible state
    logic [1:0]  neu_sel_reg,  neu_sel_next;   // Neutral command
    logic        stored_reg,   stored_next;    // Startup brake setting
    logic [1:0]  lim_cfg_reg,  lim_cfg_next;   // Limit configuration
    logic        lim_ovr_reg,  lim_ovr_next;   // Enable override flag
    logic        fwd_en_reg,   fwd_en_next;    // Forced forward enable value
    logic        rev_en_reg,   rev_en_next;    // Forced reverse enable value
    logic        fwd_no_reg,   fwd_no_next;    // Forward sense, 1 normally open
    logic        rev_no_reg,   rev_no_next;    // Reverse sense, 1 normally open
    // Pause counter and outputs
    logic [23:0] pause_reg,    pause_next;
    logic [31:0] prdata_reg,   prdata_next;
    logic        pready_reg,   pready_next;
    logic        err_reg,      err_next;
    logic        led_reg,      led_next;
    logic        brk_reg,      brk_next;
    logic        drv_reg,      drv_next;
    logic        fblk_reg,     fblk_next;
    logic        rblk_reg,     rblk_next;

    // Combinational helpers
    logic        wr_acc;       // Write in its access phase
    logic        rd_acc;       // Read in its access phase
    logic        hit;          // Address maps to a register
    logic        brake_now;    // Neutral mode in force
    logic        fwd_use;      // Forward input participates
    logic        rev_use;      // Reverse input participates
    logic        sense_chg;    // A sense write alters a setting

    // One wait state: pready is raised in the second access cycle
    assign wr_acc = psel & penable & pwrite & ~pready_reg;
    assign rd_acc = psel & penable & ~pwrite & ~pready_reg;

    // Address decode and derived behaviour
    always_comb
    begin
        hit = (paddr == `OFS_NEUTRAL_CTRL) || (paddr == `OFS_LIMIT_CTRL) ||
              (paddr == `OFS_SENSE_CTRL) || (paddr == `OFS_STATUS);
        // Override wins unless default-select, which falls back to storage
        unique case (brake_limit_pkg::neutral_cmd_e'(neu_sel_reg))
            brake_limit_pkg::neutral_force_brake:    brake_now = 1'b1;
            brake_limit_pkg::neutral_force_coast:    brake_now = 1'b0;
            brake_limit_pkg::neutral_default_select: brake_now = stored_reg;
            default:                                 brake_now = stored_reg;
        endcase
        // Disabled configuration ignores both switches; override forces each
        if (lim_cfg_reg == brake_limit_pkg::limit_cfg_all_disabled)
        begin
            fwd_use = 1'b0;
            rev_use = 1'b0;
        end
        else if (lim_ovr_reg)
        begin
            fwd_use = fwd_en_reg;
            rev_use = rev_en_reg;
        end
        else
        begin
            fwd_use = 1'b1;
            rev_use = 1'b1;
        end
        // Only a real change of sense pauses the drive
        sense_chg = wr_acc && (paddr == `OFS_SENSE_CTRL) &&
                    ((pwdata[`SNS_FWD_NO_BIT] != fwd_no_reg) ||
                     (pwdata[`SNS_REV_NO_BIT] != rev_no_reg));
    end

    // Next-state for registers, bus answer and outputs
    always_comb
    begin
        neu_sel_next = neu_sel_reg;
        stored_next  = stored_reg;
        lim_cfg_next = lim_cfg_reg;
        lim_ovr_next = lim_ovr_reg;
        fwd_en_next  = fwd_en_reg;
        rev_en_next  = rev_en_reg;
        fwd_no_next  = fwd_no_reg;
        rev_no_next  = rev_no_reg;
        prdata_next  = prdata_reg;
        pready_next  = psel & penable & ~pready_reg;
        err_next     = psel & penable & ~pready_reg & ~hit;
        // Button press toggles the startup mode
        if (cal_button)
            stored_next = ~stored_reg;
        // Register writes
        if (wr_acc)
        begin
            unique case (paddr)
                `OFS_NEUTRAL_CTRL:
                begin
                    neu_sel_next = pwdata[`NEU_SEL_LSB +: `NEU_SEL_W];
                    if (pwdata[`NEU_SEL_LSB +: `NEU_SEL_W] == 2'h3)
                        neu_sel_next = 2'h0;   // Illegal code treated as default-select
                    if (pwdata[`NEU_BUTTON_BIT])
                        stored_next = pwdata[`NEU_STORED_BIT];   // Saved configuration write
                end
                `OFS_LIMIT_CTRL:
                begin
                    lim_cfg_next = pwdata[`LIM_CFG_LSB +: `LIM_CFG_W];
                    if (pwdata[`LIM_CFG_LSB +: `LIM_CFG_W] == 2'h3)
                        lim_cfg_next = lim_cfg_reg;   // Unknown config ignored
                    lim_ovr_next = pwdata[`LIM_OVR_BIT];
                    fwd_en_next  = pwdata[`LIM_FWD_EN_BIT];
                    rev_en_next  = pwdata[`LIM_REV_EN_BIT];
                end
                `OFS_SENSE_CTRL:
                begin
                    fwd_no_next = pwdata[`SNS_FWD_NO_BIT];
                    rev_no_next = pwdata[`SNS_REV_NO_BIT];
                end
                default:
                begin
                    neu_sel_next = neu_sel_reg;   // Status and unmapped: no effect
                end
            endcase
        end
        // Register reads
        if (rd_acc)
        begin
            prdata_next = 32'h0;
            unique case (paddr)
                `OFS_NEUTRAL_CTRL:
                begin
                    prdata_next[`NEU_SEL_LSB +: `NEU_SEL_W] = neu_sel_reg;
                    prdata_next[`NEU_STORED_BIT]            = stored_reg;
                end
                `OFS_LIMIT_CTRL:
                begin
                    prdata_next[`LIM_CFG_LSB +: `LIM_CFG_W] = lim_cfg_reg;
                    prdata_next[`LIM_OVR_BIT]               = lim_ovr_reg;
                    prdata_next[`LIM_FWD_EN_BIT]            = fwd_en_reg;
                    prdata_next[`LIM_REV_EN_BIT]            = rev_en_reg;
                end
                `OFS_SENSE_CTRL:
                begin
                    prdata_next[`SNS_FWD_NO_BIT] = fwd_no_reg;
                    prdata_next[`SNS_REV_NO_BIT] = rev_no_reg;
                end
                `OFS_STATUS:
                begin
                    prdata_next[`ST_BRAKE_BIT]   = brk_reg;
                    prdata_next[`ST_FWD_ON_BIT]  = lim_ovr_reg & fwd_en_reg;
                    prdata_next[`ST_FWD_OFF_BIT] = lim_ovr_reg & ~fwd_en_reg;
                    prdata_next[`ST_REV_ON_BIT]  = lim_ovr_reg & rev_en_reg;
                    prdata_next[`ST_REV_OFF_BIT] = lim_ovr_reg & ~rev_en_reg;
                    prdata_next[`ST_FWD_BLK_BIT] = fblk_reg;
                    prdata_next[`ST_REV_BLK_BIT] = rblk_reg;
                    prdata_next[`ST_DRV_EN_BIT]  = drv_reg;
                    prdata_next[`ST_FWD_SW_BIT]  = fwd_switch_closed;
                    prdata_next[`ST_REV_SW_BIT]  = rev_switch_closed;
                end
                default:
                begin
                    prdata_next = 32'h0;   // Unmapped reads zero with pslverr
                end
            endcase
        end
        // Pause timer: reloads on every real sense change
        if (sense_chg)
            pause_next = 24'(PAUSE_CYCLES);
        else if (pause_reg != 24'h0)
            pause_next = pause_reg - 24'h1;
        else
            pause_next = pause_reg;
        // Outputs follow state one cycle later; drive enable follows the next pause count
        brk_next  = brake_now;
        led_next  = brake_now;
        drv_next  = (pause_next == 24'h0);
        // Closed switch blocks in NO, open switch blocks in NC
        fblk_next = fwd_use & (fwd_switch_closed == fwd_no_reg);
        rblk_next = rev_use & (rev_switch_closed == rev_no_reg);
    end

    // State registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            neu_sel_reg <= 2'h0;
            stored_reg  <= `RST_STORED_BRAKE;
            lim_cfg_reg <= 2'h0;
            lim_ovr_reg <= 1'b0;
            fwd_en_reg  <= 1'b1;
            rev_en_reg  <= 1'b1;
            fwd_no_reg  <= `RST_SENSE_NO;
            rev_no_reg  <= `RST_SENSE_NO;
            pause_reg   <= 24'h0;
            prdata_reg  <= 32'h0;
            pready_reg  <= 1'b0;
            err_reg     <= 1'b0;
            led_reg     <= `RST_STORED_BRAKE;
            brk_reg     <= `RST_STORED_BRAKE;
            drv_reg     <= 1'b1;
            fblk_reg    <= 1'b0;
            rblk_reg    <= 1'b0;
        end
        else
        begin
            neu_sel_reg <= neu_sel_next;
            stored_reg  <= stored_next;
            lim_cfg_reg <= lim_cfg_next;
            lim_ovr_reg <= lim_ovr_next;
            fwd_en_reg  <= fwd_en_next;
            rev_en_reg  <= rev_en_next;
            fwd_no_reg  <= fwd_no_next;
            rev_no_reg  <= rev_no_next;
            pause_reg   <= pause_next;
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            err_reg     <= err_next;
            led_reg     <= led_next;
            brk_reg     <= brk_next;
            drv_reg     <= drv_next;
            fblk_reg    <= fblk_next;
            rblk_reg    <= rblk_next;
        end
    end

    assign prdata       = prdata_reg;
    assign pready       = pready_reg;
    assign pslverr      = err_reg;
    assign brake_led    = led_reg;
    assign brake_active = brk_reg;
    assign drive_enable = drv_reg;
    assign fwd_blocked  = fblk_reg;
    assign rev_blocked  = rblk_reg;

    // Forced brake command shows on the LED next cycle
    AST_FORCE_BRAKE: assert property (@(posedge pclk) disable iff (!presetn)
        (neu_sel_reg == 2'h1) |=> brake_led) else $error("brake override not shown");
    AST_LED_MATCH: assert property (@(posedge pclk) disable iff (!presetn)
        brake_led == brake_active) else $error("LED differs from neutral mode");
    AST_DEFAULT_STORED: assert property (@(posedge pclk) disable iff (!presetn)
        (neu_sel_reg == 2'h0) |=> (brake_active == $past(stored_reg)))
        else $error("default-select not using stored mode");
    AST_FORCED_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        (lim_ovr_reg && !fwd_en_reg) |=> !fwd_blocked)
        else $error("forced-off forward input blocked drive");
    AST_DISABLED_CFG: assert property (@(posedge pclk) disable iff (!presetn)
        (lim_cfg_reg == 2'h2) |=> (!fwd_blocked && !rev_blocked))
        else $error("disabled configuration blocked drive");
    AST_PAUSE: assert property (@(posedge pclk) disable iff (!presetn)
        sense_chg |=> !drive_enable [*2]) else $error("sense change did not pause drive");
    AST_NO_PAUSE: assert property (@(posedge pclk) disable iff (!presetn)
        (pause_reg == 24'h0 && !sense_chg) |=> drive_enable)
        else $error("drive paused without cause");
    AST_NO_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
        (fwd_no_reg && !fwd_switch_closed) |=> !fwd_blocked)
        else $error("open NO switch blocked drive");
    AST_BUTTON: assert property (@(posedge pclk) disable iff (!presetn)
        (cal_button && !wr_acc) |=> (stored_reg != $past(stored_reg)))
        else $error("button did not toggle stored mode");

endmodule : brake_limit_override_ctrl

/* File: brake_limit_pkg.sv */
// Types shared by the brake/limit control
package brake_limit_pkg;

    // Neutral mode command values
    typedef enum logic [1:0] {
        neutral_default_select = 2'h0,
        neutral_force_brake    = 2'h1,
        neutral_force_coast    = 2'h2
    } neutral_cmd_e;

    // Limit configuration values
    typedef enum logic [1:0] {
        limit_cfg_switches_only     = 2'h0,
        limit_cfg_switches_and_soft = 2'h1,
        limit_cfg_all_disabled      = 2'h2
    } limit_cfg_e;

endpackage : brake_limit_pkg

/* File: ctrl_host_model.sv */
// APB configuration master standing in for the controller application
module ctrl_host_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bus idle from time zero
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
    end

    // One whole word per transfer, so override flag and both enables land together
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        // Held until pready seen high; only the bench watchdog ends a hang
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released data is scrambled so a stale value never looks valid
        pwdata  <= ~d;
    endtask : xfer
endmodule : ctrl_host_model

/* File: test_brake_limit_override_ctrl.sv */
// Self-checking bench for the brake/limit override control
`include "brake_limit_defines.svh"
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin error_cnt++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, x); end end
module test_brake_limit_override_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, cal_button;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rq, seed, r;
    logic        fwd_switch_closed, rev_switch_closed, brake_led, brake_active;
    logic        drive_enable, fwd_blocked, rev_blocked, rerr;
    logic        stored, sf, sr, ovr, fe, ren, fsw, rsw; // Expected state
    logic [1:0]  cmd, cfg, prev;
    int          error_cnt, comparisons;

    brake_limit_override_ctrl #(.PAUSE_CYCLES(4)) i_dut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cal_button, .fwd_switch_closed,
        .rev_switch_closed, .brake_led, .brake_active, .drive_enable, .fwd_blocked, .rev_blocked);
    ctrl_host_model i_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr);

    // 250 MHz clock
    always #2 pclk = ~pclk;
    // Switch levels follow the expected state at each rising edge
    always @(posedge pclk)
    begin
        fwd_switch_closed <= fsw;
        rev_switch_closed <= rsw;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // Input counts only if not disabled by config, and override picks the enable
    function automatic logic en_of(input logic e);
        return (cfg != 2'h2) && (!ovr || e);
    endfunction : en_of
    // Open sense blocks on closed switch, closed sense on open switch
    function automatic logic blk(input logic e, input logic no, input logic cl);
        return e & (no ? cl : ~cl);
    endfunction : blk
    function automatic logic brk();
        return (cmd == 2'h1) ? 1'b1 : (cmd == 2'h2) ? 1'b0 : stored;
    endfunction : brk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d, rq, rerr);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        i_host.xfer(1'b0, a, 32'h0000_0000, rq, rerr);
    endtask : rd
    task automatic set_all(input logic w, input logic v);
        wr(`OFS_NEUTRAL_CTRL, {26'h0, w, v, 2'h0, cmd});
        wr(`OFS_LIMIT_CTRL, {25'h0, ren, fe, ovr, 2'h0, cfg});
    endtask : set_all
    // Outputs lag the register by one edge; wait past that, then compare all
    task automatic check_all();
        logic        fb, rb;
        logic [31:0] st;
        fb = blk(en_of(fe), sf, fsw);
        rb = blk(en_of(ren), sr, rsw);
        st = {22'h0, rsw, fsw, 1'b1, rb, fb, ovr & ~ren, ovr & ren, ovr & ~fe, ovr & fe, brk()};
        repeat (3) @(posedge pclk);
        #1;
        `CHK(brake_active, brk())
        `CHK(brake_led, brk())
        `CHK({fwd_blocked, rev_blocked}, {fb, rb})
        rd(`OFS_STATUS);
        `CHK(rq, st)
    endtask : check_all
    // Sense change must drop drive briefly and bring it back
    task automatic pause_chk(input logic want);
        logic seen;
        seen = 1'b0;
        repeat (20)
        begin
            @(posedge pclk);
            #1;
            if (drive_enable === 1'b0) seen = 1'b1;
        end
        `CHK(seen, want)
        `CHK(drive_enable, 1'b1)
    endtask : pause_chk
    task automatic press();
        @(posedge pclk) cal_button <= 1'b1;
        @(posedge pclk) cal_button <= 1'b0;
        stored = ~stored;
    endtask : press
    task automatic close_out();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    // Watchdog well beyond the fewer than a thousand cycles the run needs
    initial
    begin
        #80000;
        error_cnt++;
        close_out();
    end

    initial
    begin
        seed = 32'h0000_3B6B;
        {presetn, cal_button, fsw, rsw, ovr, error_cnt, comparisons} = '0;
        {stored, sf, sr, fe, ren, cmd, cfg} = {5'h1F, 4'h0};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        check_all();
        wr(`OFS_SENSE_CTRL, 32'h0000_0003);
        pause_chk(1'b0);
        rd(12'h010);
        `CHK({rerr, rq}, 33'h1_0000_0000)
        wr(`OFS_STATUS, 32'hFFFF_FFFF);
        check_all();
        // Every neutral command, with the button between
        for (int c = 0; c < 4; c++)
        begin
            cmd = c[1:0];
            set_all(1'b0, 1'b0);
            check_all();
            press();
            check_all();
        end
        cmd = 2'h0;
        set_all(1'b1, 1'b0);
        stored = 1'b0;
        check_all();
        // Sense, enable and switch table under override
        ovr = 1'b1;
        for (int k = 0; k < 9; k++)
        begin
            prev = {sr, sf};
            {ren, fe} = {~k[1], k[1]};
            {sr, sf} = (k == 8) ? 2'h3 : {~k[0], k[0]};
            {rsw, fsw} = {k[2], k[2]};
            set_all(1'b0, 1'b0);
            wr(`OFS_SENSE_CTRL, {30'h0, sr, sf});
            pause_chk({sr, sf} != prev);
            check_all();
        end
        // Random mix of commands, configs, overrides and switches
        repeat (24)
        begin
            r = xs();
            cmd = r[1:0];
            cfg = (r[3:2] == 2'h3) ? 2'h0 : r[3:2];
            {ovr, fe, ren, fsw, rsw} = r[8:4];
            set_all(r[9], r[10]);
            if (r[9]) stored = r[10];
            check_all();
        end
        close_out();
    end
endmodule : test_brake_limit_override_ctrl
